// [scqm_host_model.sv]
`timescale 1ns/1ps

module scqm_host_model (
	// clock
	input wire		clock,
	// outbound entries
	input wire		out_ready,
	input wire		queue_empty,
	output reg		out_valid,
	output reg		out_is_ctrl,
	output reg [7:0]	out_data,
	output reg		reset_cmd,
	// inbound items
	input wire		in_valid,
	input wire		in_is_ctrl,
	input wire [7:0]	in_data,
	input wire [7:0]	ctrl_mode,
	output reg		in_ready
);
	logic [16:0]	in_log[$];
	int		hangs = 0;

	initial
	begin
		out_valid = 1'b0;
		out_is_ctrl = 1'b0;
		out_data = 8'h00;
		reset_cmd = 1'b0;
		in_ready = 1'b1;
	end

	always @(posedge clock)
	begin
		if (in_valid && in_ready)
		begin
			in_log.push_back({in_is_ctrl, in_data, in_is_ctrl ? ctrl_mode : 8'h00});
			in_ready <= !in_is_ctrl;
		end
		else
			in_ready <= 1'b1;
	end

	// held until out_ready; caller idles between bursts
	task send(input bit c, input [7:0] d);
		int i;
		@(negedge clock);
		out_valid = 1'b1;
		out_is_ctrl = c;
		out_data = d;
		for (i = 0; i < 2000 && hangs == 0; i++)
		begin
			@(posedge clock);
			if (out_ready === 1'b1)
				break;
		end
		if (i == 2000)
			hangs++;
	endtask

	task idle;
		@(negedge clock);
		out_valid = 1'b0;
		out_is_ctrl = ~out_is_ctrl;
		out_data = ~out_data;
	endtask

	// wait for empty queue and idle inbound unless told not to
	task card_reset(input bit early);
		int i;
		for (i = 0; i < 3000 && !early && (queue_empty !== 1'b1 || in_valid !== 1'b0); i++)
			@(posedge clock);
		@(negedge clock);
		reset_cmd = 1'b1;
		@(negedge clock);
		reset_cmd = 1'b0;
	endtask
endmodule // scqm_host_model

// [scqm_mem.v]
`timescale 1ns/1ps

module scqm_mem #(
	parameter W     = 9,
	parameter DEPTH = 1024,
	parameter AW    = 10
) (
	// clock
	input  wire          clock,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [W-1:0]  wr_data,
	// read port, data one cycle after rd_en
	input  wire          rd_en,
	input  wire [AW-1:0] rd_addr,
	output reg  [W-1:0]  rd_data
);

	reg [W-1:0] mem [0:DEPTH-1];

	always @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		if (rd_en)
			rd_data <= mem[rd_addr];
	end

endmodule // scqm_mem

// [scqm_regs.vh]
`ifndef SCQM_REGS_VH
`define SCQM_REGS_VH

// outbound control codes carried in a control entry
`define SCQM_CODE_FLUSH     8'h01

// inbound control block types
`define SCQM_TYPE_BREAK     8'hfa
`define SCQM_TYPE_CHARERR   8'hfb
`define SCQM_TYPE_EOL       8'hfc
`define SCQM_TYPE_PROMPT    8'hfd
`define SCQM_TYPE_BLKEND    8'hfe

// inbound control block modes
`define SCQM_MODE_ONE       8'h01
`define SCQM_MODE_ETB       8'h01
`define SCQM_MODE_ETX       8'h02
`define SCQM_MODE_NONE      8'h00

// type 253 block protocol mode bit positions
`define SCQM_MB_TRANSP      0
`define SCQM_MB_SEL_LO      1
`define SCQM_MB_SEL_HI      2
`define SCQM_MB_CMDCH       3

// event enable bit positions
`define SCQM_EN_BREAK       0
`define SCQM_EN_CHARERR     1
`define SCQM_EN_EOL         2
`define SCQM_EN_PROMPT      3
`define SCQM_EN_BLKEND      4
`define SCQM_EN_BLKSTART    5
`define SCQM_EN_W           6

// protocol character pass-through bit positions
`define SCQM_PASS_EOL       0
`define SCQM_PASS_PROMPT    1
`define SCQM_PASS_W         2

// substitute for a character received in error
`define SCQM_UNDERSCORE     8'h5f

// outbound block length in characters
`define SCQM_BLOCK_LEN      512

// outbound queue depth in entries
`define SCQM_QUEUE_DEPTH    1024

`endif

// [scqm_sync.v]
`timescale 1ns/1ps

module scqm_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst_n,
	// level in and synchronised level out
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end
		else
		begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;

endmodule // scqm_sync

// [scqm_top.v]
`timescale 1ns/1ps
`include "scqm_regs.vh"

module scqm_top #(
	parameter DEPTH = `SCQM_QUEUE_DEPTH,
	parameter AW    = 10,
	parameter BLK   = `SCQM_BLOCK_LEN
) (
	// clock and reset
	input  wire                 clock,
	input  wire                 rst_n,
	// configuration
	input  wire                 proto_block,
	input  wire                 half_duplex,
	input  wire                 subst_underscore,
	input  wire [`SCQM_EN_W-1:0]   event_enable,
	input  wire [`SCQM_PASS_W-1:0] pass_proto,
	// host outbound entries
	input  wire                 out_valid,
	output wire                 out_ready,
	input  wire                 out_is_ctrl,
	input  wire [7:0]           out_data,
	input  wire                 reset_cmd,
	output wire                 queue_empty,
	// forwarded outbound control entries
	output reg                  ctrl_out_valid,
	output reg  [7:0]           ctrl_out_code,
	// transmit character stream
	output wire                 tx_valid,
	input  wire                 tx_ready,
	output wire [7:0]           tx_data,
	output reg                  tx_blk_end,
	output reg                  rts,
	input  wire                 clear_to_send,
	// receive events from the line
	input  wire                 rx_valid,
	output wire                 rx_ready,
	input  wire                 rx_has_char,
	input  wire [7:0]           rx_char,
	input  wire                 rx_break,
	input  wire                 rx_frame_err,
	input  wire                 rx_parity_err,
	input  wire                 rx_eol,
	input  wire                 rx_prompt,
	input  wire                 rx_proto_char,
	input  wire                 rx_blk_start,
	input  wire                 rx_transparent,
	input  wire [1:0]           rx_select,
	input  wire                 rx_cmd_channel,
	input  wire                 rx_blk_end,
	input  wire                 rx_etx,
	// host inbound stream
	output reg                  in_valid,
	input  wire                 in_ready,
	output reg                  in_is_ctrl,
	output reg  [7:0]           in_data,
	output reg  [7:0]           ctrl_type,
	output reg  [7:0]           ctrl_mode
);

	localparam ST_IDLE = 1'b0;
	localparam ST_HOLD = 1'b1;
	localparam [31:0]   DEPTH_W  = DEPTH;
	localparam [31:0]   BLK_W    = BLK;
	localparam [31:0]   BLK_M1   = BLK - 1;
	localparam [AW:0]   DEPTH_C  = DEPTH_W[AW:0];
	localparam [AW:0]   BLK_C    = BLK_W[AW:0];
	localparam [9:0]    BLK_LAST = BLK_M1[9:0];

	wire       rst_s_n;
	wire       cts_s;
	wire [8:0] rd_data;

	reg [AW-1:0] wptr_r;
	reg [AW-1:0] rptr_r;
	reg [AW:0]   count_r;
	reg [AW:0]   data_cnt_r;
	reg [AW:0]   flush_cnt_r;
	reg          state_r;
	reg          blk_open_r;
	reg [9:0]    bcnt_r;

	reg          pre_v_r;
	reg [7:0]    pre_type_r;
	reg [7:0]    pre_mode_r;
	reg          chr_v_r;
	reg [7:0]    chr_r;
	reg          post_v_r;
	reg [7:0]    post_type_r;
	reg [7:0]    post_mode_r;

	// reset release and the clear-to-send pin both cross into this clock
	scqm_sync #(.W(1)) u_rst_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (1'b1),
		.q     (rst_s_n)
	);

	scqm_sync #(.W(1)) u_cts_sync (
		.clock (clock),
		.rst_n (rst_s_n),
		.d     (clear_to_send),
		.q     (cts_s)
	);

	wire push = out_valid && out_ready;
	wire pop_rd;
	wire ent_ctrl = rd_data[8];
	wire [7:0] ent_byte = rd_data[7:0];
	wire block_go = blk_open_r || (data_cnt_r >= BLK_C) || (flush_cnt_r != {(AW+1){1'b0}});
	wire cts_ok = proto_block || cts_s;
	wire hold_data = (state_r == ST_HOLD) && !ent_ctrl;
	wire hold_done = (state_r == ST_HOLD) && (ent_ctrl || (tx_ready && cts_ok));
	wire ent_flush = ent_ctrl && (ent_byte == `SCQM_CODE_FLUSH);

	assign pop_rd = (state_r == ST_IDLE) && (count_r != {(AW+1){1'b0}})
		&& (!proto_block || block_go) && !reset_cmd;
	// full queue stalls the host, and the reset cycle refuses entries
	assign out_ready = (count_r != DEPTH_C) && !reset_cmd;
	assign tx_valid = hold_data && cts_ok;
	assign tx_data = ent_byte;
	assign queue_empty = (count_r == {(AW+1){1'b0}}) && (state_r == ST_IDLE);

	scqm_mem #(.W(9), .DEPTH(DEPTH), .AW(AW)) u_queue (
		.clock   (clock),
		.wr_en   (push),
		.wr_addr (wptr_r),
		.wr_data ({out_is_ctrl, out_data}),
		.rd_en   (pop_rd),
		.rd_addr (rptr_r),
		.rd_data (rd_data)
	);

	wire [AW:0] data_inc = (push && !out_is_ctrl) ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
	wire [AW:0] data_dec = (hold_done && !ent_ctrl) ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
	wire        fl_push = push && out_is_ctrl && (out_data == `SCQM_CODE_FLUSH);
	wire [AW:0] fl_inc = fl_push ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
	wire [AW:0] fl_dec = (hold_done && ent_flush) ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
	wire [AW:0] cnt_inc = push ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
	wire [AW:0] cnt_dec = pop_rd ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};

	always @(posedge clock or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			wptr_r         <= {AW{1'b0}};
			rptr_r         <= {AW{1'b0}};
			count_r        <= {(AW+1){1'b0}};
			data_cnt_r     <= {(AW+1){1'b0}};
			flush_cnt_r    <= {(AW+1){1'b0}};
			state_r        <= ST_IDLE;
			blk_open_r     <= 1'b0;
			bcnt_r         <= 10'h000;
			tx_blk_end     <= 1'b0;
			ctrl_out_valid <= 1'b0;
			ctrl_out_code  <= 8'h00;
			rts            <= 1'b1;
		end
		else if (reset_cmd)
		begin
			wptr_r         <= {AW{1'b0}};
			rptr_r         <= {AW{1'b0}};
			count_r        <= {(AW+1){1'b0}};
			data_cnt_r     <= {(AW+1){1'b0}};
			flush_cnt_r    <= {(AW+1){1'b0}};
			state_r        <= ST_IDLE;
			blk_open_r     <= 1'b0;
			bcnt_r         <= 10'h000;
			tx_blk_end     <= 1'b0;
			ctrl_out_valid <= 1'b0;
			rts            <= 1'b1;
		end
		else
		begin
			tx_blk_end     <= 1'b0;
			ctrl_out_valid <= 1'b0;
			if (push)
				wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
			if (pop_rd)
				rptr_r <= rptr_r + {{(AW-1){1'b0}}, 1'b1};
			count_r     <= count_r + cnt_inc - cnt_dec;
			data_cnt_r  <= data_cnt_r + data_inc - data_dec;
			flush_cnt_r <= flush_cnt_r + fl_inc - fl_dec;
			case (state_r)
				ST_IDLE:
				begin
					if (pop_rd)
						state_r <= ST_HOLD;
				end
				ST_HOLD:
				begin
					if (hold_done)
					begin
						state_r <= ST_IDLE;
						if (!ent_ctrl)
						begin
							if (!proto_block && half_duplex)
								rts <= 1'b1;
							if (proto_block)
							begin
								if (bcnt_r == BLK_LAST)
								begin
									bcnt_r     <= 10'h000;
									blk_open_r <= 1'b0;
									tx_blk_end <= 1'b1;
								end
								else
								begin
									bcnt_r     <= bcnt_r + 10'h001;
									blk_open_r <= 1'b1;
								end
							end
						end
						else if (ent_flush)
						begin
							if (!proto_block && half_duplex)
								rts <= 1'b0;
							if (proto_block)
							begin
								bcnt_r     <= 10'h000;
								blk_open_r <= 1'b0;
								tx_blk_end <= 1'b1;
							end
						end
						else
						begin
							ctrl_out_valid <= 1'b1;
							ctrl_out_code  <= ent_byte;
						end
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// inbound: each line event splits into a block before, a character, and a block after
	wire       ev_err = rx_has_char && (rx_frame_err || rx_parity_err);
	wire [7:0] err_mode = {6'h00, rx_parity_err, rx_frame_err};
	reg        pre_v_nxt;
	reg [7:0]  pre_type_nxt;
	reg [7:0]  pre_mode_nxt;
	reg        chr_v_nxt;
	reg [7:0]  chr_nxt;
	reg        post_v_nxt;
	reg [7:0]  post_type_nxt;
	reg [7:0]  post_mode_nxt;

	always @*
	begin
		pre_v_nxt     = 1'b0;
		pre_type_nxt  = `SCQM_TYPE_BREAK;
		pre_mode_nxt  = `SCQM_MODE_ONE;
		chr_v_nxt     = rx_has_char;
		chr_nxt       = rx_char;
		post_v_nxt    = 1'b0;
		post_type_nxt = `SCQM_TYPE_EOL;
		post_mode_nxt = `SCQM_MODE_ONE;
		if (!proto_block)
		begin
			if (rx_break)
			begin
				pre_v_nxt = event_enable[`SCQM_EN_BREAK];
			end
			else if (ev_err)
			begin
				if (subst_underscore)
					chr_nxt = `SCQM_UNDERSCORE;
				else
				begin
					pre_v_nxt    = event_enable[`SCQM_EN_CHARERR];
					pre_type_nxt = `SCQM_TYPE_CHARERR;
					pre_mode_nxt = err_mode;
				end
			end
			if (rx_eol)
			begin
				chr_v_nxt  = rx_has_char && pass_proto[`SCQM_PASS_EOL];
				post_v_nxt = event_enable[`SCQM_EN_EOL];
			end
			else if (rx_prompt)
			begin
				chr_v_nxt     = rx_has_char && pass_proto[`SCQM_PASS_PROMPT];
				post_v_nxt    = event_enable[`SCQM_EN_PROMPT];
				post_type_nxt = `SCQM_TYPE_PROMPT;
			end
		end
		else
		begin
			chr_v_nxt = rx_has_char && !rx_proto_char;
			if (rx_blk_start)
			begin
				pre_v_nxt    = event_enable[`SCQM_EN_BLKSTART];
				pre_type_nxt = `SCQM_TYPE_PROMPT;
				pre_mode_nxt = `SCQM_MODE_NONE;
				pre_mode_nxt[`SCQM_MB_TRANSP] = rx_transparent;
				pre_mode_nxt[`SCQM_MB_SEL_LO] = rx_select[0];
				pre_mode_nxt[`SCQM_MB_SEL_HI] = rx_select[1];
				pre_mode_nxt[`SCQM_MB_CMDCH]  = rx_cmd_channel;
			end
			if (rx_blk_end)
			begin
				post_v_nxt    = event_enable[`SCQM_EN_BLKEND];
				post_type_nxt = `SCQM_TYPE_BLKEND;
				post_mode_nxt = rx_etx ? `SCQM_MODE_ETX : `SCQM_MODE_ETB;
			end
		end
	end

	// a new line event is taken once the previous one has left all three staging slots; its last item may still wait in in_valid
	assign rx_ready = !pre_v_r && !chr_v_r && !post_v_r && !reset_cmd;
	wire take = rx_valid && rx_ready;
	wire slot_free = !in_valid || in_ready;

	always @(posedge clock or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			pre_v_r     <= 1'b0;
			pre_type_r  <= 8'h00;
			pre_mode_r  <= 8'h00;
			chr_v_r     <= 1'b0;
			chr_r       <= 8'h00;
			post_v_r    <= 1'b0;
			post_type_r <= 8'h00;
			post_mode_r <= 8'h00;
			in_valid    <= 1'b0;
			in_is_ctrl  <= 1'b0;
			in_data     <= 8'h00;
			ctrl_type   <= 8'h00;
			ctrl_mode   <= 8'h00;
		end
		else if (reset_cmd)
		begin
			pre_v_r  <= 1'b0;
			chr_v_r  <= 1'b0;
			post_v_r <= 1'b0;
			in_valid <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				pre_v_r     <= pre_v_nxt;
				pre_type_r  <= pre_type_nxt;
				pre_mode_r  <= pre_mode_nxt;
				chr_v_r     <= chr_v_nxt;
				chr_r       <= chr_nxt;
				post_v_r    <= post_v_nxt;
				post_type_r <= post_type_nxt;
				post_mode_r <= post_mode_nxt;
			end
			if (slot_free)
			begin
				in_valid <= 1'b0;
				if (pre_v_r)
				begin
					pre_v_r    <= 1'b0;
					in_valid   <= 1'b1;
					in_is_ctrl <= 1'b1;
					in_data    <= pre_type_r;
					ctrl_type  <= pre_type_r;
					ctrl_mode  <= pre_mode_r;
				end
				else if (chr_v_r)
				begin
					chr_v_r    <= 1'b0;
					in_valid   <= 1'b1;
					in_is_ctrl <= 1'b0;
					in_data    <= chr_r;
				end
				else if (post_v_r)
				begin
					post_v_r   <= 1'b0;
					in_valid   <= 1'b1;
					in_is_ctrl <= 1'b1;
					in_data    <= post_type_r;
					ctrl_type  <= post_type_r;
					ctrl_mode  <= post_mode_r;
				end
			end
		end
	end

endmodule // scqm_top

// [scqm_top_bench.sv]
`timescale 1ns/1ps

module scqm_top_bench;
	logic		clock = 1'b0, rst_n = 1'b0, tx_ready = 1'b1, tx_stall = 1'b0;
	logic		proto_block = 1'b0, half_duplex = 1'b0, subst_underscore = 1'b0;
	logic		clear_to_send = 1'b1, rx_valid = 1'b0;
	logic [5:0]	event_enable = 6'h3f;
	logic [1:0]	pass_proto = 2'h0;
	logic [7:0]	rx_char = 8'h00;
	logic [13:0]	rx_f = 14'h0000;
	wire		out_valid, out_ready, out_is_ctrl, reset_cmd, queue_empty, ctrl_out_valid;
	wire		tx_valid, tx_blk_end, rts, rx_ready, in_valid, in_ready, in_is_ctrl;
	wire [7:0]	out_data, ctrl_out_code, tx_data, in_data, ctrl_type, ctrl_mode;
	wire		rx_has_char, rx_break, rx_frame_err, rx_parity_err, rx_eol, rx_prompt;
	wire		rx_proto_char, rx_blk_start, rx_transparent, rx_cmd_channel, rx_blk_end, rx_etx;
	wire [1:0]	rx_select;
	int		bad_count = 0, comparisons = 0, blk_cnt = 0;
	logic [16:0]	out_log[$], exp_in[$];
	localparam [13:0] HAS = 14'h2000, BRK = 14'h1000, FE = 14'h0800, PE = 14'h0400;
	localparam [13:0] EOL = 14'h0200, PRM = 14'h0100, PRT = 14'h0080, BST = 14'h0040;
	localparam [13:0] TRN = 14'h0020, SEL1 = 14'h0008, CMD = 14'h0004, BEND = 14'h0002;

	assign {rx_has_char, rx_break, rx_frame_err, rx_parity_err, rx_eol, rx_prompt, rx_proto_char,
		rx_blk_start, rx_transparent, rx_select, rx_cmd_channel, rx_blk_end, rx_etx} = rx_f;

	scqm_top dut (.clock, .rst_n, .proto_block, .half_duplex, .subst_underscore, .event_enable,
		.pass_proto, .out_valid, .out_ready, .out_is_ctrl, .out_data, .reset_cmd, .queue_empty,
		.ctrl_out_valid, .ctrl_out_code, .tx_valid, .tx_ready, .tx_data, .tx_blk_end, .rts,
		.clear_to_send, .rx_valid, .rx_ready, .rx_has_char, .rx_char, .rx_break, .rx_frame_err,
		.rx_parity_err, .rx_eol, .rx_prompt, .rx_proto_char, .rx_blk_start, .rx_transparent,
		.rx_select, .rx_cmd_channel, .rx_blk_end, .rx_etx, .in_valid, .in_ready, .in_is_ctrl,
		.in_data, .ctrl_type, .ctrl_mode);
	scqm_host_model host (.clock, .out_ready, .queue_empty, .out_valid, .out_is_ctrl, .out_data,
		.reset_cmd, .in_valid, .in_is_ctrl, .in_data, .ctrl_mode, .in_ready);

	initial
		forever #2.5 clock = ~clock;
	// a stalling line takes every other cycle
	always @(negedge clock)
		tx_ready <= tx_stall ? ~tx_ready : 1'b1;
	always @(posedge clock)
	begin
		if (tx_valid && tx_ready)
			out_log.push_back({8'h00, 1'b0, tx_data});
		if (ctrl_out_valid)
			out_log.push_back({8'h00, 1'b1, ctrl_out_code});
		if (tx_blk_end)
			blk_cnt++;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk_flag(string n, logic e, logic g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_item(string n, logic [16:0] e, logic [16:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	function logic [16:0] pop_out();
		if (out_log.size() == 0)
			return 'x;
		return out_log.pop_front();
	endfunction
	task wait_for(int n);
		int i;
		for (i = 0; i < 5000 && out_log.size() < n; i++)
			@(posedge clock);
		if (i == 5000)
		begin
			chk_item("tx count", n, out_log.size());
			finish_test;
		end
		repeat (10) @(posedge clock);
	endtask
	task rx_ev(input [7:0] ch, input [13:0] f);
		int i;
		@(negedge clock);
		rx_valid = 1'b1;
		rx_char = ch;
		rx_f = f;
		for (i = 0; i < 100; i++)
		begin
			@(posedge clock);
			if (rx_ready === 1'b1)
				break;
		end
		if (i == 100)
		begin
			chk_flag("rx_ready", 1, rx_ready);
			finish_test;
		end
		@(negedge clock);
		rx_valid = 1'b0;
		rx_char = ~ch;
		rx_f = ~f;
	endtask
	task chk_in;
		repeat (20) @(posedge clock);
		while (exp_in.size() > 0)
			chk_item("inbound", exp_in.pop_front(), host.in_log.size() ? host.in_log.pop_front() : 'x);
		chk_item("inbound extra", 0, host.in_log.size());
	endtask

	task t_order;
		host.send(1, 8'h33);
		host.send(0, 8'h41);
		host.send(1, 8'h34);
		host.send(0, 8'h42);
		host.idle;
		chk_flag("queue_empty", 0, queue_empty);
		wait_for(4);
		chk_flag("queue_empty", 1, queue_empty);
		chk_item("order", 17'h133, pop_out());
		chk_item("order", 17'h041, pop_out());
		chk_item("order", 17'h134, pop_out());
		chk_item("order", 17'h042, pop_out());
	endtask
	task t_reset_cmd;
		@(negedge clock);
		clear_to_send = 1'b0;
		repeat (5) @(posedge clock);
		host.send(0, 8'h51);
		host.send(0, 8'h52);
		host.idle;
		repeat (10) @(posedge clock);
		chk_flag("queue_empty", 0, queue_empty);
		host.card_reset(1);
		chk_flag("queue_empty", 1, queue_empty);
		clear_to_send = 1'b1;
		repeat (20) @(posedge clock);
		chk_item("tx after reset", 0, out_log.size());
	endtask
	task t_half;
		@(negedge clock);
		half_duplex = 1'b1;
		host.send(0, 8'h61);
		host.send(1, 8'h01);
		host.idle;
		wait_for(1);
		chk_flag("rts", 0, rts);
		host.send(0, 8'h62);
		host.idle;
		wait_for(2);
		chk_flag("rts", 1, rts);
		@(negedge clock);
		half_duplex = 1'b0;
		host.send(1, 8'h01);
		host.idle;
		repeat (20) @(posedge clock);
		chk_flag("rts", 1, rts);
		chk_item("half", 17'h061, pop_out());
		chk_item("half", 17'h062, pop_out());
		chk_item("half extra", 0, out_log.size());
	endtask
	task t_block;
		@(negedge clock);
		proto_block = 1'b1;
		tx_stall = 1'b1;
		blk_cnt = 0;
		for (int i = 0; i < 511; i++)
			host.send(0, i[7:0]);
		host.idle;
		repeat (50) @(posedge clock);
		chk_item("partial block", 0, out_log.size());
		host.send(0, 8'hff);
		host.idle;
		wait_for(512);
		chk_item("block ends", 1, blk_cnt);
		for (int i = 0; i < 512; i++)
			chk_item("block data", (i == 511) ? 17'h0ff : i[7:0], pop_out());
		host.send(0, 8'ha1);
		host.send(0, 8'ha2);
		host.send(1, 8'h01);
		host.idle;
		wait_for(2);
		chk_item("block ends", 2, blk_cnt);
		chk_item("short block", 17'h0a1, pop_out());
		chk_item("short block", 17'h0a2, pop_out());
		tx_stall = 1'b0;
	endtask
	task t_inbound;
		@(negedge clock);
		proto_block = 1'b0;
		rx_ev(8'h00, BRK);
		exp_in = '{{9'h1fa, 8'h01}};
		chk_in;
		rx_ev(8'h41, HAS | FE);
		rx_ev(8'h42, HAS | PE);
		rx_ev(8'h43, HAS | FE | PE);
		exp_in = '{{9'h1fb, 8'h01}, 17'h04100, {9'h1fb, 8'h02}, 17'h04200, {9'h1fb, 8'h03}, 17'h04300};
		chk_in;
		rx_ev(8'h0d, HAS | EOL);
		rx_ev(8'h3e, HAS | PRM);
		pass_proto = 2'h1;
		rx_ev(8'h0d, HAS | EOL);
		exp_in = '{{9'h1fc, 8'h01}, {9'h1fd, 8'h01}, 17'h00d00, {9'h1fc, 8'h01}};
		chk_in;
		subst_underscore = 1'b1;
		rx_ev(8'h44, HAS | PE);
		exp_in = '{17'h05f00};
		chk_in;
		subst_underscore = 1'b0;
		event_enable = 6'h00;
		rx_ev(8'h00, BRK);
		rx_ev(8'h0d, HAS | EOL);
		exp_in = '{17'h00d00};
		chk_in;
		event_enable = 6'h3f;
		proto_block = 1'b1;
		rx_ev(8'h00, BST | TRN | SEL1 | CMD);
		rx_ev(8'h55, HAS);
		rx_ev(8'h02, HAS | PRT);
		rx_ev(8'h00, BEND | 14'h0001);
		rx_ev(8'h00, BEND);
		rx_ev(8'h00, BST | 14'h0010);
		exp_in = '{{9'h1fd, 8'h0b}, 17'h05500, {9'h1fe, 8'h02}, {9'h1fe, 8'h01}, {9'h1fd, 8'h04}};
		chk_in;
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(posedge clock);
		chk_flag("queue_empty", 1, queue_empty);
		chk_flag("rts", 1, rts);
		t_order;
		t_reset_cmd;
		t_half;
		t_block;
		t_inbound;
		chk_item("host hangs", 0, host.hangs);
		finish_test;
	end
endmodule // scqm_top_bench

// [scqm_top_chk.sv]
`timescale 1ns/1ps
`include "scqm_regs.vh"

module scqm_top_chk (
	// clock and reset
	input wire		clock,
	input wire		rst_n,
	// configuration
	input wire		proto_block,
	input wire		half_duplex,
	input wire		subst_underscore,
	// outbound and transmit
	input wire		out_valid,
	input wire		out_ready,
	input wire		reset_cmd,
	input wire		queue_empty,
	input wire		tx_valid,
	input wire		tx_ready,
	input wire [7:0]	tx_data,
	input wire		rts,
	// inbound
	input wire		rx_ready,
	input wire		in_valid,
	input wire		in_ready,
	input wire		in_is_ctrl,
	input wire [7:0]	in_data,
	input wire [7:0]	ctrl_type,
	input wire [7:0]	ctrl_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_take;
		out_valid && out_ready;
	endsequence
	sequence s_ctl;
		in_valid && in_is_ctrl;
	endsequence

	a_fill_empty: assert property (s_take |=> !queue_empty)
		else $error("queue_empty high after an entry was taken");
	a_reset_refuse: assert property (reset_cmd |-> !out_ready && !rx_ready)
		else $error("entries accepted during card reset");
	a_reset_clear: assert property (reset_cmd |=> queue_empty && rts && !tx_valid && !in_valid)
		else $error("state left over after card reset");
	a_tx_hold: assert property (tx_valid && !tx_ready && !reset_cmd |=> tx_valid && $stable(tx_data))
		else $error("transmit character changed before taken");
	a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("characters offered closer than two cycles");
	a_in_hold: assert property (in_valid && !in_ready && !reset_cmd |=> in_valid && $stable(in_data))
		else $error("inbound item changed before taken");
	a_status_type: assert property (s_ctl |-> ctrl_type == in_data)
		else $error("status type differs from the offered block");
	a_err_kind: assert property (s_ctl ##0 in_data == `SCQM_TYPE_CHARERR |-> !subst_underscore && !proto_block && ctrl_mode inside {8'h01, 8'h02, 8'h03})
		else $error("bad character error block");
	a_one_mode: assert property (s_ctl ##0 (in_data == `SCQM_TYPE_BREAK || in_data == `SCQM_TYPE_EOL) |-> ctrl_mode == 8'h01)
		else $error("break or end-of-line block mode not one");
	a_blk_mode: assert property (s_ctl ##0 in_data == `SCQM_TYPE_BLKEND |-> proto_block && (ctrl_mode == 8'h01 || ctrl_mode == 8'h02))
		else $error("block end mode out of range");
	a_rts_fall: assert property ($fell(rts) |-> $past(half_duplex) && !$past(proto_block))
		else $error("request-to-send dropped outside async half duplex");
endmodule // scqm_top_chk

bind scqm_top scqm_top_chk chk (.clock, .rst_n, .proto_block, .half_duplex, .subst_underscore,
	.out_valid, .out_ready, .reset_cmd, .queue_empty, .tx_valid, .tx_ready, .tx_data, .rts,
	.rx_ready, .in_valid, .in_ready, .in_is_ctrl, .in_data, .ctrl_type, .ctrl_mode);
